// ### aie_add_exec.sv
// Decode and four-phase execution of the two add instructions
`timescale 1ns/1ps

// Operation
// - Upper byte 0Fh: add immediate, low byte literal
// - Working register plus literal into working register
// - Read file byte, add working register, flags
// - Destination bit: zero working, one file
// - Access bit zero access bank, one banked
// - Extended set, access zero, offset<=5Fh: indexed
module aie_add_exec
  import aie_pkg::*;
(
  input  wire logic        mclk_i,            // Core clock
  input  wire logic        rst_n_i,           // Asynchronous reset, active low
  input  wire logic        instr_valid_i,     // Instruction word offered
  input  wire logic [15:0] instr_i,           // Fetched instruction word
  input  wire logic        ext_set_en_i,      // Extended instruction set enabled
  input  wire logic [3:0]  bank_pointer_reg_i,// Bank pointer register
  input  wire logic [11:0] index_base_i,      // Base pointer for indexed mode
  input  wire logic [7:0]  mem_rdata_i,       // File byte, one cycle after read strobe
  output logic             busy_o,            // Instruction in progress
  output logic             done_o,            // Pulse in the write phase
  output logic             unsupported_o,     // Pulse: offered word is not an add
  output logic             mem_rd_o,          // File read strobe
  output logic             mem_wr_o,          // File write strobe
  output logic [11:0]      mem_addr_o,        // File address
  output logic [7:0]       mem_wdata_o,       // File write data
  output logic [7:0]       wreg_o,            // Working register
  output logic [4:0]       status_o           // Negative, wrap, zero, half carry, carry
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Used both for acceptance and for the unsupported pulse
  function automatic logic is_add_imm(input logic [15:0] word);
    return word[15:8] == ADD_IMM_OPCODE;
  endfunction

  function automatic logic is_add_file(input logic [15:0] word);
    return word[15:10] == ADD_FILE_OPCODE;
  endfunction

  // Effective file address from the encoding and bank state
  function automatic logic [11:0] file_addr(input logic [15:0] word,
                                            input logic        ext_en,
                                            input logic [3:0]  bank,
                                            input logic [11:0] base);
    logic [7:0] ofs;
    ofs = word[7:0];
    if (word[ACCESS_BIT]) begin
      file_addr = {bank, ofs};
    end else if (ext_en && (ofs <= INDEX_LIMIT)) begin
      file_addr = base + {4'h0, ofs};
    end else if (ofs < ACCESS_SPLIT) begin
      file_addr = {ACCESS_LO_BANK, ofs};
    end else begin
      // Upper access half
      file_addr = {ACCESS_HI_BANK, ofs};
    end
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  aie_phase_t  phase;        // Current phase
  logic        op_file;      // Latched: add_to_file_op
  logic        dest_file;    // Latched: result to file
  logic [7:0]  literal;      // Latched immediate
  logic [7:0]  operand;      // Second operand for processing
  logic        accept;       // Decode accepts an add
  aie_alu_if   alu_bus ();   // Adder connection

  // Accept only in decode; words offered mid-instruction are dropped
  assign accept = (phase == AIE_DECODE) && instr_valid_i &&
                  (is_add_imm(instr_i) || is_add_file(instr_i));

  // One adder serves both operations; it only ever sees operands
  aie_adder u_adder (
    .alu (alu_bus.alu)
  );

  // Working register always feeds the first adder input
  assign alu_bus.op_a = wreg_o;
  assign alu_bus.op_b = operand;

  // ==========================================================
  // Phase sequencer
  // ==========================================================
  // Decode, read, process, write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase <= AIE_DECODE;
    end else begin
      // No stall: an accepted word always runs all four phases
      case (phase)
        AIE_DECODE:  phase <= accept ? AIE_READ : AIE_DECODE;
        AIE_READ:    phase <= AIE_PROCESS;
        AIE_PROCESS: phase <= AIE_WRITE;
        AIE_WRITE:   phase <= AIE_DECODE;
        default:     phase <= AIE_DECODE;
      endcase
    end
  end

  // Busy covers read, process and write phases
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= accept || (phase == AIE_READ) || (phase == AIE_PROCESS);
    end
  end

  // Non-add words are flagged, not executed
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unsupported_o <= 1'b0;
    end else begin
      unsupported_o <= (phase == AIE_DECODE) && instr_valid_i && !accept;
    end
  end

  // ==========================================================
  // Decode latch
  // ==========================================================
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_file   <= 1'b0;
      dest_file <= 1'b0;
      literal   <= 8'h00;
    end else if (accept) begin
      op_file   <= is_add_file(instr_i);
      dest_file <= is_add_file(instr_i) && instr_i[DEST_BIT];
      literal   <= instr_i[7:0];
    end
  end

  // ==========================================================
  // Memory port
  // ==========================================================
  // Address held from read through write so one address serves both
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_o <= 12'h000;
    end else if (accept && is_add_file(instr_i)) begin
      mem_addr_o <= file_addr(instr_i, ext_set_en_i, bank_pointer_reg_i, index_base_i);
    end
  end

  // Read strobe in the read phase
  // One-cycle pulse; the file must answer in the next cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_o <= 1'b0;
    end else begin
      mem_rd_o <= accept && is_add_file(instr_i);
    end
  end

  // Second operand: file byte arrives during process phase
  // Limitation: file byte is not registered, it must stand that cycle
  always_comb begin
    if (op_file) begin
      operand = mem_rdata_i;
    end else begin
      operand = literal;
    end
  end

  // File write in the write phase
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_wr_o <= (phase == AIE_PROCESS) && dest_file;
      if (phase == AIE_PROCESS) begin
        mem_wdata_o <= alu_bus.sum;
      end
    end
  end

  // ==========================================================
  // Working register and flags
  // ==========================================================
  // Sum to working register unless file destination
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wreg_o <= W_RESET;
    end else if ((phase == AIE_PROCESS) && !dest_file) begin
      wreg_o <= alu_bus.sum;
    end
  end

  // Flags updated by both adds
  // Flags follow the sum whatever its destination
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= STATUS_RESET;
    end else if (phase == AIE_PROCESS) begin
      status_o <= alu_bus.flags;
    end
  end

  // Completion pulse lines up with the write strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= (phase == AIE_PROCESS);
    end
  end

endmodule // aie_add_exec

// ### aie_pkg.sv
// Shared constants for the add instruction execute block
package aie_pkg;

  // ==========================================================
  // Instruction encodings
  // ==========================================================
  localparam logic [7:0]  ADD_IMM_OPCODE  = 8'h0F;   // Upper byte of add_immediate_op
  localparam logic [5:0]  ADD_FILE_OPCODE = 6'h09;   // Bits 15:10 of add_to_file_op
  localparam int          DEST_BIT        = 9;       // Destination select position
  localparam int          ACCESS_BIT      = 8;       // Bank access select position

  // ==========================================================
  // Addressing constants
  // ==========================================================
  localparam logic [7:0]  INDEX_LIMIT     = 8'h5F;   // Highest offset using indexed mode
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;   // Access bank low/high boundary
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;    // Bank of upper access half
  localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;    // Bank of lower access half

  // ==========================================================
  // Status flag positions and reset values
  // ==========================================================
  localparam int          FLAG_C          = 0;       // Carry
  localparam int          FLAG_HALF       = 1;       // half_carry_flag
  localparam int          FLAG_Z          = 2;       // Zero
  localparam int          FLAG_WRAP       = 3;       // signed_wrap_flag
  localparam int          FLAG_N          = 4;       // Negative
  localparam logic [7:0]  W_RESET         = 8'h00;   // Working register after reset
  localparam logic [4:0]  STATUS_RESET    = 5'h00;   // Flags after reset

  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    AIE_DECODE,
    AIE_READ,
    AIE_PROCESS,
    AIE_WRITE
  } aie_phase_t;

endpackage

// ### aie_alu_if.sv
// Operand and result bundle between the sequencer and the adder
`timescale 1ns/1ps
interface aie_alu_if;
  logic [7:0] op_a;     // Working register operand
  logic [7:0] op_b;     // Literal or file operand
  logic [7:0] sum;      // Eight-bit result
  logic [4:0] flags;    // Flags from the addition

  modport seq (output op_a, output op_b, input sum, input flags);
  modport alu (input op_a, input op_b, output sum, output flags);
endinterface

// ### aie_adder.sv
// Eight-bit adder producing the five status flags
`timescale 1ns/1ps
module aie_adder
  import aie_pkg::*;
(
  aie_alu_if.alu alu
);

  // ==========================================================
  // Addition
  // ==========================================================
  logic [8:0] full_sum;   // Sum with carry out
  logic [4:0] low_sum;    // Low nibble sum with half carry

  // Sum and flags, purely combinational
  always_comb begin
    full_sum              = {1'b0, alu.op_a} + {1'b0, alu.op_b};
    low_sum               = {1'b0, alu.op_a[3:0]} + {1'b0, alu.op_b[3:0]};
    alu.sum               = full_sum[7:0];
    alu.flags             = STATUS_RESET;
    alu.flags[FLAG_C]     = full_sum[8];
    alu.flags[FLAG_HALF]  = low_sum[4];
    alu.flags[FLAG_Z]     = (full_sum[7:0] == 8'h00);
    // Same-sign operands giving opposite-sign result wrap
    alu.flags[FLAG_WRAP]  = (alu.op_a[7] == alu.op_b[7]) && (full_sum[7] != alu.op_a[7]);
    alu.flags[FLAG_N]     = full_sum[7];
  end

endmodule // aie_adder

// ### aie_add_exec_chk.sv
// Concurrent checks on the ports of the add execute block
`timescale 1ns/1ps
module aie_add_exec_chk
  import aie_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic        ext_set_en_i,
  input wire logic [3:0]  bank_pointer_reg_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        unsupported_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [11:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  wreg_o,
  input wire logic [4:0]  status_o
);
  // ==========================================
  // Accept decode, idle means not busy and not writing
  logic acc;  // Word taken this edge
  logic lit;  // Taken as add immediate
  logic fil;  // Taken as add to file
  assign acc = instr_valid_i && !busy_o && !done_o;
  assign lit = acc && instr_i[15:8] == ADD_IMM_OPCODE;
  assign fil = acc && instr_i[15:10] == ADD_FILE_OPCODE;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Assertions
  a_lit_sum: assert property (lit |-> ##3 done_o &&
    wreg_o == 8'($past(wreg_o, 3) + $past(instr_i[7:0], 3))) else $error("literal sum wrong");
  a_lit_no_mem: assert property (lit |=> !mem_rd_o ##2 !mem_wr_o)
    else $error("literal op touched file");
  a_file_read: assert property (fil |=> mem_rd_o ##1 !mem_rd_o)
    else $error("file read strobe wrong");
  a_dest_select: assert property (fil |-> ##3 done_o &&
    mem_wr_o == $past(instr_i[DEST_BIT], 3)) else $error("destination wrong");
  a_wdata_sum: assert property (mem_wr_o |->
    mem_wdata_o == 8'(wreg_o + $past(mem_rdata_i))) else $error("write data wrong");
  a_bank_addr: assert property (fil && instr_i[ACCESS_BIT] |=>
    mem_addr_o == {$past(bank_pointer_reg_i), $past(instr_i[7:0])}) else $error("banked addr");
  a_index_addr: assert property (fil && !instr_i[ACCESS_BIT] && ext_set_en_i &&
    instr_i[7:0] <= INDEX_LIMIT |=> mem_addr_o == 12'($past(index_base_i) + $past(instr_i[7:0])))
    else $error("indexed addr");
  a_four_phase: assert property ($rose(busy_o) |-> busy_o[*2] ##1 (busy_o && done_o) ##1 !busy_o)
    else $error("phase count wrong");
  a_refuse_other: assert property (acc && !lit && !fil |=> unsupported_o && !busy_o)
    else $error("non add word not refused");
  // Main scenarios seen
  c_lit: cover property (lit ##3 done_o);
  c_file_wr: cover property (fil ##3 mem_wr_o);
  c_refuse: cover property (unsupported_o);
endmodule // aie_add_exec_chk

bind aie_add_exec aie_add_exec_chk chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .ext_set_en_i(ext_set_en_i),
  .bank_pointer_reg_i(bank_pointer_reg_i), .index_base_i(index_base_i),
  .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o), .unsupported_o(unsupported_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .wreg_o(wreg_o), .status_o(status_o));

// ### tb.sv
// Self-checking bench for the add execute block
`timescale 1ns/1ps
module tb
  import aie_pkg::*;
;
  // ==========================================
  // Design ports and model state
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic        ext_set_en_i = 1'b0;
  logic [3:0]  bank_pointer_reg_i = 4'h0;
  logic [11:0] index_base_i = 12'h000;
  logic [7:0]  mem_rdata_i = 8'h00;
  logic        busy_o, done_o, unsupported_o, mem_rd_o, mem_wr_o;
  logic [11:0] mem_addr_o;
  logic [7:0]  mem_wdata_o, wreg_o;
  logic [4:0]  status_o;
  logic [7:0]  fmem [int];     // File bytes, filled on first touch
  logic [7:0]  w_m;            // Model working register
  logic [4:0]  st_m;           // Model flags
  logic [15:0] dir_q [$] = '{16'h0F15, 16'h0F80, 16'h0F80, 16'h245F, 16'h2660,
                             16'h2480, 16'h257F, 16'h27C2, 16'h0E01};
  int          num_errors = 0;
  int          n_checks = 0;

  aie_add_exec dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .ext_set_en_i(ext_set_en_i), .bank_pointer_reg_i(bank_pointer_reg_i),
    .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o),
    .unsupported_o(unsupported_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .wreg_o(wreg_o), .status_o(status_o));

  // 200 MHz clock
  always #2.5 mclk_i = ~mclk_i;

  // ==========================================
  // Compare tasks and closing
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flags got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // One instruction, four cycles, model updated alongside
  task automatic op(input logic [15:0] ins, input logic ext, input logic [3:0] bk,
                    input logic [11:0] bs);
    logic [11:0] ad;
    logic [7:0]  f, b, r;
    logic [8:0]  s;
    logic        isl, isf;
    f = ins[7:0];
    isl = ins[15:8] == ADD_IMM_OPCODE;
    isf = ins[15:10] == ADD_FILE_OPCODE;
    // Address form: banked, indexed, or split access bank
    ad = ins[ACCESS_BIT] ? {bk, f} : (ext && f <= INDEX_LIMIT) ? bs + 12'(f) :
         {(f < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, f};
    if (!fmem.exists(int'(ad))) fmem[int'(ad)] = 8'($urandom);
    b = isf ? fmem[int'(ad)] : f;
    s = {1'b0, w_m} + {1'b0, b};
    r = s[7:0];
    @(posedge mclk_i); #1;
    instr_valid_i = 1'b1; instr_i = ins; ext_set_en_i = ext;
    bank_pointer_reg_i = bk; index_base_i = bs;
    @(posedge mclk_i); #1;
    // Offer a junk word for one cycle, in the read phase; it must be ignored
    instr_valid_i = isl || isf;
    instr_i = 16'hFFFF;
    chk_val(16'(unsupported_o), 16'(!(isl || isf)));
    if (!(isl || isf)) return;
    chk_val(16'({busy_o, mem_rd_o}), 16'({1'b1, isf}));
    if (isf) chk_val(16'(mem_addr_o), 16'(ad));
    @(posedge mclk_i); #1;
    instr_valid_i = 1'b0;
    mem_rdata_i = b;
    chk_val(16'(unsupported_o), 16'h0000);
    @(posedge mclk_i); #1;
    mem_rdata_i = ~b;  // Read hold is over, show a changed value
    chk_val(16'({done_o, busy_o, mem_wr_o}), 16'({2'b11, isf & ins[DEST_BIT]}));
    st_m = {r[7], (w_m[7] == b[7]) && (r[7] != w_m[7]), r == 8'h00,
            (5'(w_m[3:0]) + 5'(b[3:0])) > 5'h0F, s[8]};
    chk_flag(status_o, st_m);
    if (isf && ins[DEST_BIT]) begin
      chk_val(16'(mem_wdata_o), 16'(r));
      fmem[int'(ad)] = r;
    end else w_m = r;
    chk_val(16'(wreg_o), 16'(w_m));
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] ins;
    void'($urandom(32'h2b67));
    repeat (12) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    w_m = W_RESET;
    chk_val(16'(wreg_o), 16'(W_RESET));
    chk_flag(status_o, STATUS_RESET);
    $display("test reset done");
    foreach (dir_q[i]) op(dir_q[i], 1'b1, 4'($urandom), 12'($urandom));
    $display("test directed done");
    repeat (300) begin
      case ($urandom_range(0, 3))
        0: ins = {ADD_IMM_OPCODE, 8'($urandom)};
        1: ins = 16'($urandom);
        default: ins = {ADD_FILE_OPCODE, 10'($urandom)};
      endcase
      op(ins, 1'($urandom), 4'($urandom), 12'($urandom));
    end
    $display("test random done");
    report_and_stop();
  end

  // Hang guard, well past the expected run length
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb
